/* bench/ssc_checker.sv */
// port-level assertions for the standby sensing block
`timescale 1ns/100ps
`default_nettype none
module ssc_checker (
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_rd_en,
    input  wire logic [7:0] reg_rdata_q,
    input  wire logic       standby_active,
    input  wire logic [6:0] standby_threshold,
    input  wire logic       meas_run_q,
    input  wire logic [2:0] meas_chan_q,
    input  wire logic       low_power_q,
    input  wire logic       result_valid_q,
    input  wire logic [2:0] result_chan_q,
    input  wire logic [7:0] result_delta_q,
    input  wire logic [5:0] touch_q
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic unmapped;
    assign unmapped = !(reg_addr inside {8'h38, 8'h40, 8'h41, 8'h42});
    rd_unmapped_a: assert property (reg_rd_en && unmapped |=> reg_rdata_q == 8'h00)
        else $error("unmapped read not zero");
    rd_hold_a: assert property (!reg_rd_en |=> $stable(reg_rdata_q))
        else $error("read data moved without a read");
    gain_mask_a: assert property (reg_rd_en && reg_addr == 8'h42 |=> reg_rdata_q[7:3] == 5'h00)
        else $error("gain upper bits not zero");
    ratio_mask_a: assert property (reg_rd_en && reg_addr == 8'h38 |=> reg_rdata_q[7:2] == 6'h00)
        else $error("noise ratio upper bits not zero");
    cycle_start_a: assert property ($rose(standby_active) |-> ##[1:2] (meas_run_q || low_power_q))
        else $error("standby cycle did not start");
    off_quiet_a: assert property (!standby_active |=> !meas_run_q && !low_power_q && touch_q == 6'h00)
        else $error("activity outside standby");
    power_excl_a: assert property (!(meas_run_q && low_power_q))
        else $error("sampling while idle");
    chan_range_a: assert property (meas_run_q |-> meas_chan_q < 3'd6)
        else $error("sampled channel out of range");
    result_pulse_a: assert property (result_valid_q |=> !result_valid_q)
        else $error("result pulse too long");
    touch_cmp_a: assert property (result_valid_q |=> touch_q[$past(result_chan_q)] ==
        ($past(result_delta_q) > {1'b0, standby_threshold})) else $error("touch flag wrong");
endmodule : ssc_checker
bind ssc_standby ssc_checker u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_rd_en(reg_rd_en), .reg_rdata_q(reg_rdata_q), .standby_active(standby_active),
    .standby_threshold(standby_threshold), .meas_run_q(meas_run_q), .meas_chan_q(meas_chan_q),
    .low_power_q(low_power_q), .result_valid_q(result_valid_q), .result_chan_q(result_chan_q),
    .result_delta_q(result_delta_q), .touch_q(touch_q));
`default_nettype wire

/* bench/ssc_front_end.sv */
// front end model that hands raw counts to the standby sequencer
`timescale 1ns/100ps
`default_nettype none
module ssc_front_end (
    input  wire logic                      meas_run_q,
    input  wire logic [ssc_pkg::RAW_W-1:0] raw_level,
    output logic      [ssc_pkg::RAW_W-1:0] sample_raw
);
    // outside sampling the count is stale, so show its inverse
    assign sample_raw = meas_run_q ? raw_level : ~raw_level;
endmodule : ssc_front_end
`default_nettype wire

/* bench/standby_sense_config_bench.sv */
// self-checking bench for the standby sensing block
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin fails++; \
    $display("unexpected t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module standby_sense_config_bench;
    typedef struct packed {
        logic [7:0] cfg; logic [2:0] gain; logic [1:0] ratio; logic [5:0] chan;
        logic [15:0] raw; logic dis; logic [7:0] delta; logic tch; logic [7:0] recal;
    } ssc_row_t;
    localparam ssc_row_t ROWS [8] = '{
        '{8'h10, 3'd0, 2'd1, 6'h05, 16'h0010, 1'b0, 8'h20, 1'b1, 8'h04},
        '{8'h90, 3'd0, 2'd1, 6'h01, 16'h0010, 1'b0, 8'h40, 1'b1, 8'h02}, // small sum only
        '{8'h00, 3'd0, 2'd0, 6'h02, 16'h0004, 1'b0, 8'h08, 1'b0, 8'h00},
        '{8'h00, 3'd0, 2'd3, 6'h02, 16'h0004, 1'b0, 8'h08, 1'b0, 8'h01},
        '{8'h00, 3'd7, 2'd1, 6'h20, 16'h2000, 1'b0, 8'h80, 1'b1, 8'h01},
        '{8'h24, 3'd2, 2'd1, 6'h10, 16'h0040, 1'b0, 8'h20, 1'b1, 8'h04},
        '{8'h00, 3'd0, 2'd2, 6'h04, 16'h0006, 1'b1, 8'h0C, 1'b0, 8'h01},
        '{8'h03, 3'd0, 2'd1, 6'h08, 16'hFFFF, 1'b0, 8'hFF, 1'b1, 8'h01}};
    localparam logic [7:0] ADR [5] = '{8'h38, 8'h40, 8'h41, 8'h42, 8'h43};
    localparam logic [7:0] RSTV [5] = '{8'h01, 8'h00, 8'h39, 8'h02, 8'h00};
    localparam logic [7:0] MSK [5] = '{8'h03, 8'h3F, 8'hFF, 8'h07, 8'h00};
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic        reg_wr_en = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_rd_en = 1'b0;
    logic        standby_active = 1'b0;
    logic [6:0]  standby_threshold = 7'h10;
    logic        noise_filter_disable = 1'b0;
    logic [15:0] raw_level = 16'h0000;
    logic [15:0] sample_raw;
    logic [15:0] recal_sample_q;
    logic [7:0]  reg_rdata_q, result_delta_q, recal_seen;
    logic        meas_run_q, low_power_q, result_valid_q, recal_valid_q;
    logic [2:0]  meas_chan_q, result_chan_q;
    logic [5:0]  touch_q;
    int          fails = 0;
    int          check_count = 0;
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (recal_valid_q === 1'b1) recal_seen <= recal_seen + 8'h01;
    ssc_front_end u_fe (.meas_run_q(meas_run_q), .raw_level(raw_level), .sample_raw(sample_raw));
    ssc_standby #(.SAMPLE_UNIT(4), .CYCLE_UNIT(200)) u_dut (.ref_clk(ref_clk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
        .reg_rdata_q(reg_rdata_q), .standby_active(standby_active),
        .standby_threshold(standby_threshold), .noise_filter_disable(noise_filter_disable),
        .sample_raw(sample_raw), .meas_run_q(meas_run_q), .meas_chan_q(meas_chan_q),
        .low_power_q(low_power_q), .result_valid_q(result_valid_q),
        .result_chan_q(result_chan_q), .result_delta_q(result_delta_q), .touch_q(touch_q),
        .recal_valid_q(recal_valid_q), .recal_sample_q(recal_sample_q));
    task automatic final_report;
        if (fails == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge ref_clk);
        reg_wr_en = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge ref_clk);
        reg_rd_en = 1'b0;
        q = reg_rdata_q;
    endtask : rd
    task automatic wait_res;
        int n;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (result_valid_q !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            fails++;
            final_report();
        end
    endtask : wait_res
    initial begin
        logic [7:0] q;
        repeat (4) @(negedge ref_clk);
        rst_b = 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(ADR[i], q);
            `CHK(q, RSTV[i])
            wr(ADR[i], 8'hFF);
            rd(ADR[i], q);
            `CHK(q, MSK[i])
        end
        for (int i = 0; i < 8; i++) begin
            wr(ssc_pkg::ADDR_NOISE_RATIO, {6'h00, ROWS[i].ratio});
            wr(ssc_pkg::ADDR_STBY_CHAN, {2'b00, ROWS[i].chan});
            wr(ssc_pkg::ADDR_STBY_CFG, ROWS[i].cfg);
            wr(ssc_pkg::ADDR_STBY_GAIN, {5'h00, ROWS[i].gain});
            raw_level = ROWS[i].raw;
            noise_filter_disable = ROWS[i].dis;
            recal_seen = 8'h00;
            standby_active = 1'b1;
            for (int j = 0; j < 6; j++) begin
                if (ROWS[i].chan[j]) begin
                    wait_res();
                    `CHK(result_chan_q, 3'(j))
                    `CHK(result_delta_q, ROWS[i].delta)
                end
            end
            repeat (2) @(negedge ref_clk);
            `CHK(low_power_q, 1'b1)
            `CHK(touch_q, ROWS[i].tch ? ROWS[i].chan : 6'h00)
            `CHK(recal_seen, ROWS[i].recal)
            standby_active = 1'b0;
            repeat (2) @(negedge ref_clk);
        end
        // sampling longer than the period, with a channel change mid-cycle
        wr(ssc_pkg::ADDR_STBY_CFG, 8'h60);
        wr(ssc_pkg::ADDR_STBY_CHAN, 8'h01);
        raw_level = 16'h0010;
        standby_active = 1'b1;
        repeat (3) @(negedge ref_clk);
        `CHK(meas_chan_q, 3'h0)
        `CHK(meas_run_q, 1'b1)
        wr(ssc_pkg::ADDR_STBY_CHAN, 8'h02);
        wait_res();
        `CHK(result_chan_q, 3'h0)
        `CHK(result_delta_q, 8'h20)
        `CHK(recal_sample_q, 16'h0010)
        @(negedge ref_clk);
        `CHK(low_power_q, 1'b0)
        `CHK(meas_run_q, 1'b1)
        `CHK(meas_chan_q, 3'h1)
        wait_res();
        `CHK(result_chan_q, 3'h1)
        standby_active = 1'b0;
        // reset one cycle after standby is dropped returns outputs and registers to defaults
        @(negedge ref_clk);
        rst_b = 1'b0;
        @(negedge ref_clk);
        `CHK(low_power_q, 1'b0)
        `CHK(touch_q, 6'h00)
        rst_b = 1'b1;
        rd(ssc_pkg::ADDR_STBY_CHAN, q);
        `CHK(q, 8'h00)
        rd(ssc_pkg::ADDR_STBY_CFG, q);
        `CHK(q, 8'h39)
        final_report();
    end
endmodule : standby_sense_config_bench
`default_nettype wire

/* hw/ssc_gain_scale.sv */
// scales a combined raw count into an 8-bit delta count by gain code
`timescale 1ns/100ps
`default_nettype none
module ssc_gain_scale (
    input  wire logic [ssc_pkg::SUM_W-1:0] raw,
    input  wire logic [2:0]                gain,
    output logic      [7:0]                delta
);
    logic [ssc_pkg::SUM_W:0] wide_w;

    // msb weight is 64 raw counts at code 0, doubling per code up to 8192
    assign wide_w = {raw, 1'b0} >> gain;
    assign delta  = (|wide_w[ssc_pkg::SUM_W:8]) ? 8'hFF : wide_w[7:0];
endmodule : ssc_gain_scale
`default_nettype wire

/* hw/ssc_noise_gate.sv */
// decides whether one sample may feed recalibration
`timescale 1ns/100ps
`default_nettype none
module ssc_noise_gate (
    input  wire logic [7:0] delta,
    input  wire logic [6:0] touch_thr,
    input  wire logic [1:0] ratio,
    input  wire logic       filter_disable,
    output logic            use_sample
);
    function automatic logic [7:0] noise_level(input logic [6:0] t, input logic [1:0] r);
        logic [7:0] q;
        logic [7:0] e;
        logic [7:0] h;
        q = {3'h0, t[6:2]};
        e = {4'h0, t[6:3]};
        h = {2'h0, t[6:1]};
        unique case (r)
            2'b00: noise_level = q;
            2'b01: noise_level = q + e;
            2'b10: noise_level = h;
            2'b11: noise_level = h + e;
        endcase
    endfunction : noise_level

    logic [7:0] level_w;
    logic       spike_w;

    assign level_w    = noise_level(touch_thr, ratio);
    assign spike_w    = (delta > level_w) && (delta <= {1'b0, touch_thr});
    assign use_sample = filter_disable || !spike_w;
endmodule : ssc_noise_gate
`default_nettype wire

/* hw/ssc_pkg.sv */
// constants for the standby sensing configuration block
package ssc_pkg;
    localparam logic [7:0] ADDR_NOISE_RATIO = 8'h38;
    localparam logic [7:0] ADDR_STBY_CHAN   = 8'h40;
    localparam logic [7:0] ADDR_STBY_CFG    = 8'h41;
    localparam logic [7:0] ADDR_STBY_GAIN   = 8'h42;

    localparam logic [7:0] RST_NOISE_RATIO  = 8'h01;
    localparam logic [7:0] RST_STBY_CHAN    = 8'h00;
    localparam logic [7:0] RST_STBY_CFG     = 8'h39;
    localparam logic [7:0] RST_STBY_GAIN    = 8'h02;

    localparam logic [7:0] MASK_NOISE_RATIO = 8'h03;
    localparam logic [7:0] MASK_STBY_CHAN   = 8'h3F;
    localparam logic [7:0] MASK_STBY_CFG    = 8'hFF;
    localparam logic [7:0] MASK_STBY_GAIN   = 8'h07;

    localparam int CFG_ACC_BIT    = 7;
    localparam int CFG_COUNT_MSB  = 6;
    localparam int CFG_COUNT_LSB  = 4;
    localparam int CFG_STIME_MSB  = 3;
    localparam int CFG_STIME_LSB  = 2;
    localparam int CFG_PERIOD_MSB = 1;
    localparam int CFG_PERIOD_LSB = 0;

    localparam int NUM_INPUTS     = 6;
    localparam int RAW_W          = 16;
    localparam int SUM_W          = 23;
    localparam int TIME_W         = 26;

    localparam int CLK_PERIOD_NS  = 100;
    localparam int SAMPLE_UNIT_NS = 320000;
    localparam int CYCLE_UNIT_NS  = 35000000;
    localparam int SAMPLE_UNIT_CYC = SAMPLE_UNIT_NS / CLK_PERIOD_NS;
    localparam int CYCLE_UNIT_CYC  = CYCLE_UNIT_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        SSC_OFF    = 2'b00,
        SSC_SAMPLE = 2'b01,
        SSC_IDLE   = 2'b11
    } ssc_state_t;
endpackage : ssc_pkg

/* hw/ssc_standby.sv */
// standby sensing configuration registers and standby measurement sequencer
`timescale 1ns/100ps
`default_nettype none
module ssc_standby #(
    parameter int SAMPLE_UNIT = ssc_pkg::SAMPLE_UNIT_CYC,
    parameter int CYCLE_UNIT  = ssc_pkg::CYCLE_UNIT_CYC
) (
    input  wire logic                        ref_clk,
    input  wire logic                        rst_b,
    input  wire logic [7:0]                  reg_addr,
    input  wire logic                        reg_wr_en,
    input  wire logic [7:0]                  reg_wdata,
    input  wire logic                        reg_rd_en,
    output logic      [7:0]                  reg_rdata_q,
    input  wire logic                        standby_active,
    input  wire logic [6:0]                  standby_threshold,
    input  wire logic                        noise_filter_disable,
    input  wire logic [ssc_pkg::RAW_W-1:0]   sample_raw,
    output logic                             meas_run_q,
    output logic      [2:0]                  meas_chan_q,
    output logic                             low_power_q,
    output logic                             result_valid_q,
    output logic      [2:0]                  result_chan_q,
    output logic      [7:0]                  result_delta_q,
    output logic      [5:0]                  touch_q,
    output logic                             recal_valid_q,
    output logic      [ssc_pkg::RAW_W-1:0]   recal_sample_q
);
    localparam logic [2:0] NO_CHAN = 3'h7;
    localparam logic [ssc_pkg::TIME_W-1:0] S_UNIT = ssc_pkg::TIME_W'(SAMPLE_UNIT);
    localparam logic [ssc_pkg::TIME_W-1:0] C_UNIT = ssc_pkg::TIME_W'(CYCLE_UNIT);

    // first enabled input at or above index from, or none
    function automatic logic [2:0] next_chan(input logic [5:0] ena, input logic [3:0] from);
        next_chan = NO_CHAN;
        for (int i = ssc_pkg::NUM_INPUTS - 1; i >= 0; i--) begin
            if (ena[i] && (4'(i) >= from)) begin
                next_chan = 3'(i);
            end
        end
    endfunction : next_chan

    logic [7:0]                  noise_ratio_q;
    logic [7:0]                  chan_ena_q;
    logic [7:0]                  cfg_q;
    logic [7:0]                  gain_q;
    logic [5:0]                  act_ena_q;
    logic [7:0]                  act_cfg_q;
    logic [2:0]                  act_gain_q;
    ssc_pkg::ssc_state_t         state_q;
    ssc_pkg::ssc_state_t         state_d;
    logic [ssc_pkg::TIME_W-1:0]  cyc_q;
    logic [ssc_pkg::TIME_W-1:0]  tmr_q;
    logic [7:0]                  smp_cnt_q;
    logic [ssc_pkg::SUM_W-1:0]   sum_q;

    // register decode
    logic       wr_noise_w;
    logic       wr_chan_w;
    logic       wr_cfg_w;
    logic       wr_gain_w;
    logic [7:0] rd_mux_w;

    assign wr_noise_w = reg_wr_en && (reg_addr == ssc_pkg::ADDR_NOISE_RATIO);
    assign wr_chan_w  = reg_wr_en && (reg_addr == ssc_pkg::ADDR_STBY_CHAN);
    assign wr_cfg_w   = reg_wr_en && (reg_addr == ssc_pkg::ADDR_STBY_CFG);
    assign wr_gain_w  = reg_wr_en && (reg_addr == ssc_pkg::ADDR_STBY_GAIN);
    assign rd_mux_w   = (reg_addr == ssc_pkg::ADDR_NOISE_RATIO) ? noise_ratio_q :
                        (reg_addr == ssc_pkg::ADDR_STBY_CHAN)   ? chan_ena_q :
                        (reg_addr == ssc_pkg::ADDR_STBY_CFG)    ? cfg_q :
                        (reg_addr == ssc_pkg::ADDR_STBY_GAIN)   ? gain_q : 8'h00;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            noise_ratio_q <= ssc_pkg::RST_NOISE_RATIO;
            chan_ena_q    <= ssc_pkg::RST_STBY_CHAN;
            cfg_q         <= ssc_pkg::RST_STBY_CFG;
            gain_q        <= ssc_pkg::RST_STBY_GAIN;
            reg_rdata_q   <= 8'h00;
        end else begin
            if (wr_noise_w) noise_ratio_q <= reg_wdata & ssc_pkg::MASK_NOISE_RATIO;
            if (wr_chan_w)  chan_ena_q    <= reg_wdata & ssc_pkg::MASK_STBY_CHAN;
            if (wr_cfg_w)   cfg_q         <= reg_wdata & ssc_pkg::MASK_STBY_CFG;
            if (wr_gain_w)  gain_q        <= reg_wdata & ssc_pkg::MASK_STBY_GAIN;
            if (reg_rd_en)  reg_rdata_q   <= rd_mux_w;
        end
    end

    // timing decode from the active snapshot
    logic [ssc_pkg::TIME_W-1:0] samp_len_w;
    logic [ssc_pkg::TIME_W-1:0] period_w;
    logic [7:0]                 num_samp_w;
    logic [2:0]                 count_code_w;

    assign count_code_w = act_cfg_q[ssc_pkg::CFG_COUNT_MSB:ssc_pkg::CFG_COUNT_LSB];
    assign num_samp_w   = 8'h01 << count_code_w;
    assign samp_len_w   = S_UNIT << act_cfg_q[ssc_pkg::CFG_STIME_MSB:ssc_pkg::CFG_STIME_LSB];
    assign period_w     = ssc_pkg::TIME_W'(C_UNIT *
                          ({24'h0, act_cfg_q[ssc_pkg::CFG_PERIOD_MSB:ssc_pkg::CFG_PERIOD_LSB]}
                           + 26'h1));

    // sequencing events
    logic       samp_done_w;
    logic       last_samp_w;
    logic [2:0] nxt_w;
    logic [2:0] first_w;
    logic       period_over_w;
    logic       cyc_start_w;

    assign samp_done_w   = (state_q == ssc_pkg::SSC_SAMPLE) && (tmr_q == samp_len_w - 26'h1);
    assign last_samp_w   = samp_done_w && (smp_cnt_q == num_samp_w - 8'h01);
    assign nxt_w         = next_chan(act_ena_q, {1'b0, meas_chan_q} + 4'h1);
    assign first_w       = next_chan(chan_ena_q[5:0], 4'h0);
    assign period_over_w = (cyc_q >= period_w - 26'h1);
    // a new cycle starts after idle time, or right after sampling that ran long
    assign cyc_start_w   = standby_active && ((state_q == ssc_pkg::SSC_OFF) ||
                           ((state_q == ssc_pkg::SSC_IDLE) && period_over_w) ||
                           (last_samp_w && nxt_w == NO_CHAN && period_over_w));

    always_comb begin
        state_d = state_q;
        if (!standby_active) begin
            state_d = ssc_pkg::SSC_OFF;
        end else if (cyc_start_w) begin
            state_d = (first_w == NO_CHAN) ? ssc_pkg::SSC_IDLE : ssc_pkg::SSC_SAMPLE;
        end else if (last_samp_w && nxt_w == NO_CHAN) begin
            state_d = ssc_pkg::SSC_IDLE;
        end
    end

    // combined result and per-sample scaling
    logic [ssc_pkg::SUM_W-1:0] sum_d_w;
    logic [ssc_pkg::SUM_W-1:0] comb_w;
    logic [7:0]                comb_delta_w;
    logic [7:0]                samp_delta_w;
    logic                      use_w;

    assign sum_d_w = sum_q + {7'h00, sample_raw};
    assign comb_w  = act_cfg_q[ssc_pkg::CFG_ACC_BIT] ? sum_d_w : (sum_d_w >> count_code_w);

    ssc_gain_scale u_comb_gain (
        .raw   (comb_w),
        .gain  (act_gain_q),
        .delta (comb_delta_w)
    );

    ssc_gain_scale u_samp_gain (
        .raw   ({7'h00, sample_raw}),
        .gain  (act_gain_q),
        .delta (samp_delta_w)
    );

    ssc_noise_gate u_noise (
        .delta          (samp_delta_w),
        .touch_thr      (standby_threshold),
        .ratio          (noise_ratio_q[1:0]),
        .filter_disable (noise_filter_disable),
        .use_sample     (use_w)
    );

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q    <= ssc_pkg::SSC_OFF;
            act_ena_q  <= 6'h00;
            act_cfg_q  <= ssc_pkg::RST_STBY_CFG;
            act_gain_q <= ssc_pkg::RST_STBY_GAIN[2:0];
        end else begin
            state_q <= state_d;
            if (cyc_start_w) begin
                act_ena_q  <= chan_ena_q[5:0];
                act_cfg_q  <= cfg_q;
                act_gain_q <= gain_q[2:0];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cyc_q       <= '0;
            tmr_q       <= '0;
            smp_cnt_q   <= 8'h00;
            sum_q       <= '0;
            meas_chan_q <= 3'h0;
        end else if (cyc_start_w) begin
            cyc_q       <= '0;
            tmr_q       <= '0;
            smp_cnt_q   <= 8'h00;
            sum_q       <= '0;
            meas_chan_q <= first_w;
        end else begin
            cyc_q <= period_over_w ? cyc_q : cyc_q + 26'h1;
            if (samp_done_w) begin
                tmr_q <= '0;
                if (last_samp_w) begin
                    smp_cnt_q   <= 8'h00;
                    sum_q       <= '0;
                    meas_chan_q <= nxt_w;
                end else begin
                    smp_cnt_q <= smp_cnt_q + 8'h01;
                    sum_q     <= sum_d_w;
                end
            end else if (state_q == ssc_pkg::SSC_SAMPLE) begin
                tmr_q <= tmr_q + 26'h1;
            end
        end
    end

    // status and result outputs
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            meas_run_q     <= 1'b0;
            low_power_q    <= 1'b0;
            result_valid_q <= 1'b0;
            result_chan_q  <= 3'h0;
            result_delta_q <= 8'h00;
            touch_q        <= 6'h00;
            recal_valid_q  <= 1'b0;
            recal_sample_q <= '0;
        end else begin
            meas_run_q     <= (state_d == ssc_pkg::SSC_SAMPLE);
            low_power_q    <= (state_d == ssc_pkg::SSC_IDLE);
            result_valid_q <= last_samp_w;
            recal_valid_q  <= samp_done_w && use_w;
            if (samp_done_w) begin
                recal_sample_q <= sample_raw;
            end
            if (!standby_active) begin
                touch_q <= 6'h00;
            end
            if (last_samp_w) begin
                result_chan_q  <= meas_chan_q;
                result_delta_q <= comb_delta_w;
                touch_q[meas_chan_q] <= (comb_delta_w > {1'b0, standby_threshold});
            end
        end
    end
endmodule : ssc_standby
`default_nettype wire
